// [design/iim_regs.sv]
/*
 Interrupt mask, status and holding registers of a two-wire serial controller.
 Assumes an APB master on pclk and a serial engine on the same clock that
 drives the flag levels, event pulses and the holding-register handshakes.
*/
// Design decisions made here: register access over APB and the placing of the registers.
// Notes on behaviour
// - Writing the enable-set register sets every mask bit written as one.
// - Writing the enable-clear register clears every mask bit written as one.
// - The mask state register reads back the current mask, one meaning enabled.
// - All three mask registers share one map of ten flag positions.
// - Bits 3, 7 and 12 to 31 are reserved, ignored and read zero.
// - The receive holding register shows the last received byte in bits 7 to 0.
// - Software writes the next byte to send into bits 7 to 0 of transmit holding.
// - The transmit holding empty flag drops when transmit holding is written.
// - Receive ready rises when a byte arrives and falls when it is read.
// - Event flags such as arbitration lost clear when the status register is read.
`timescale 1ns/1ps
module iim_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iim_pkg::ADDR_W-1:0] paddr,
	input wire logic [iim_pkg::DATA_W-1:0] pwdata,
	output logic [iim_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire iim_pkg::iim_eng_t eng,
	output logic [iim_pkg::BYTE_W-1:0] tx_byte,
	output logic tx_holding_empty,
	output logic rx_byte_ready
);
	import iim_pkg::*;

	// ==========================================================
	// Declarations.
	logic cap;
	iim_reg_t cap_reg;
	iim_reg_t take_reg;
	logic wr_take;
	logic rd_take;
	logic [NFLAG-1:0] mask;
	logic [NFLAG-1:0] next_mask;
	logic [NFLAG-1:0] flags;
	logic [NFLAG-1:0] snap;
	logic [NFLAG-1:0] wr_bits;
	logic [NFLAG-1:0] set_vec;
	logic [NFLAG-1:0] clr_vec;
	logic [NFLAG-1:0] clr_status;
	logic [NFLAG-1:0] clr_sw;
	logic [BYTE_W-1:0] rx_hold;
	logic [DATA_W-1:0] rd_value;
	logic wr_set;
	logic wr_clear;
	logic wr_status_clear;
	logic wr_tx;
	logic rd_status;
	logic rd_rx;
	logic any_pending;

	// ==========================================================
	// Bus front end.
	iim_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pready(pready),
		.pslverr(pslverr),
		.cap(cap),
		.cap_reg(cap_reg),
		.take_reg(take_reg),
		.wr_take(wr_take),
		.rd_take(rd_take)
	);

	// ==========================================================
	// Write and read strobes, one per register except the mask state register.
	assign wr_set = wr_take && (take_reg == REG_IRQ_ENABLE_SET);
	assign wr_clear = wr_take && (take_reg == REG_IRQ_ENABLE_CLEAR);
	assign wr_status_clear = wr_take && (take_reg == REG_STATUS_CLEAR);
	assign wr_tx = wr_take && (take_reg == REG_TX_BYTE_HOLDING);
	assign rd_status = rd_take && (take_reg == REG_STATUS);
	assign rd_rx = rd_take && (take_reg == REG_RX_BYTE_HOLDING);
	assign wr_bits = pwdata[NFLAG-1:0] & FLAG_VALID;

	// ==========================================================
	// Interrupt mask.
	assign next_mask = (mask | (wr_set ? wr_bits : '0))
		& ~(wr_clear ? wr_bits : '0);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= MASK_RESET;
		end else begin
			mask <= next_mask;
		end
	end

	// ==========================================================
	// Holding registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_hold <= BYTE_RESET;
		end else if (eng.rx_load) begin
			rx_hold <= eng.rx_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_byte <= BYTE_RESET;
		end else if (wr_tx) begin
			tx_byte <= pwdata[BYTE_W-1:0];
		end
	end

	// ==========================================================
	// Status flags.
	// Only flags that were seen by the read are cleared, so an event that
	// lands between setup and access is kept for the next read.
	assign clr_status = rd_status ? (snap & FLAG_EVENT) : '0;
	assign clr_sw = wr_status_clear ? (pwdata[NFLAG-1:0] & FLAG_EVENT) : '0;
	assign set_vec = (eng.event_set & FLAG_EVENT)
		| (NFLAG'(eng.rx_load) << BIT_RX_BYTE_READY)
		| (NFLAG'(eng.tx_take) << BIT_TX_HOLDING_EMPTY);
	assign clr_vec = clr_status
		| clr_sw
		| (NFLAG'(rd_rx) << BIT_RX_BYTE_READY)
		| (NFLAG'(wr_tx) << BIT_TX_HOLDING_EMPTY);

	iim_flag_bank #(
		.WIDTH(NFLAG),
		.LEVEL(FLAG_LEVEL),
		.RESET(FLAG_RESET)
	) u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(eng.level & FLAG_LEVEL),
		.set_in(set_vec),
		.clr_in(clr_vec),
		.flags(flags)
	);

	assign tx_holding_empty = flags[BIT_TX_HOLDING_EMPTY];
	assign rx_byte_ready = flags[BIT_RX_BYTE_READY];

	// ==========================================================
	// Read data, captured in the setup cycle.
	assign rd_value = (cap_reg == REG_STATUS) ? {{(DATA_W-NFLAG){1'b0}}, flags} :
		(cap_reg == REG_IRQ_MASK_STATE) ? {{(DATA_W-NFLAG){1'b0}}, mask} :
		(cap_reg == REG_RX_BYTE_HOLDING) ? {{(DATA_W-BYTE_W){1'b0}}, rx_hold} :
		(cap_reg == REG_TX_BYTE_HOLDING) ? {{(DATA_W-BYTE_W){1'b0}}, tx_byte} : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			snap <= '0;
		end else if (cap && !pwrite) begin
			prdata <= rd_value;
			snap <= flags;
		end
	end

	// ==========================================================
	// Interrupt output.
	// Registered so the pin is glitch free, at the cost of one cycle of lag.
	assign any_pending = |(flags & mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= any_pending;
		end
	end

	// ==========================================================
	// Assertions.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_enable_set;
		wr_set |=> mask == ($past(mask) | ($past(pwdata[NFLAG-1:0]) & FLAG_VALID));
	endproperty
	a_enable_set: assert property (p_enable_set)
		else $error("Enable-set write did not set the written mask bits.");

	property p_enable_clear;
		wr_clear |=> mask == ($past(mask) & ~($past(pwdata[NFLAG-1:0]) & FLAG_VALID));
	endproperty
	a_enable_clear: assert property (p_enable_clear)
		else $error("Enable-clear write did not clear the written mask bits.");

	property p_mask_read;
		(cap && !pwrite && cap_reg == REG_IRQ_MASK_STATE) ##1 rd_take
			|-> prdata == {{(DATA_W-NFLAG){1'b0}}, $past(mask)};
	endproperty
	a_mask_read: assert property (p_mask_read)
		else $error("Mask state read returned a wrong value.");

	property p_bit_map;
		(eng.event_set[BIT_ARBITRATION_LOST] && mask[BIT_ARBITRATION_LOST] && !wr_clear)
			|-> ##2 irq;
	endproperty
	a_bit_map: assert property (p_bit_map)
		else $error("Arbitration lost event at its mapped bit gave no interrupt.");

	property p_reserved;
		(mask & ~FLAG_VALID) == '0 && (flags & ~FLAG_VALID) == '0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("A reserved bit became set.");

	property p_rx_hold;
		eng.rx_load ##1 (cap && !pwrite && cap_reg == REG_RX_BYTE_HOLDING && !eng.rx_load)
			|=> prdata == {{(DATA_W-BYTE_W){1'b0}}, $past(eng.rx_data, 2)};
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("Receive holding read did not return the last byte.");

	property p_tx_byte;
		wr_tx |=> tx_byte == $past(pwdata[BYTE_W-1:0]);
	endproperty
	a_tx_byte: assert property (p_tx_byte)
		else $error("Transmit holding write did not reach the engine.");

	property p_tx_empty_drop;
		(wr_tx && !eng.tx_take) |=> !tx_holding_empty;
	endproperty
	a_tx_empty_drop: assert property (p_tx_empty_drop)
		else $error("Transmit empty flag stayed high after a write.");

	property p_rx_ready_set;
		eng.rx_load |=> rx_byte_ready;
	endproperty
	a_rx_ready_set: assert property (p_rx_ready_set)
		else $error("Receive ready did not rise on a received byte.");

	property p_rx_ready_clr;
		(rd_rx && !eng.rx_load) |=> !rx_byte_ready;
	endproperty
	a_rx_ready_clr: assert property (p_rx_ready_clr)
		else $error("Receive ready did not fall after the read.");

	property p_arb_clear;
		(rd_status && snap[BIT_ARBITRATION_LOST] && !eng.event_set[BIT_ARBITRATION_LOST])
			|=> !flags[BIT_ARBITRATION_LOST];
	endproperty
	a_arb_clear: assert property (p_arb_clear)
		else $error("Arbitration lost survived a status read.");

	property p_set_wins;
		eng.event_set[BIT_ARBITRATION_LOST] |=> flags[BIT_ARBITRATION_LOST];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("An arriving event was lost to a clear.");

	property p_irq_follows;
		any_pending |=> irq;
	endproperty
	a_irq_follows: assert property (p_irq_follows)
		else $error("Interrupt low while an enabled flag is set.");

	property p_irq_quiet;
		!any_pending |=> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet)
		else $error("Interrupt high with no enabled flag.");

	// ==========================================================
	// Coverage.
	property p_cov_enable;
		wr_set ##1 wr_clear;
	endproperty
	c_cov_enable: cover property (p_cov_enable);

	property p_cov_status_clear;
		rd_status && (snap & FLAG_EVENT) != '0;
	endproperty
	c_cov_status_clear: cover property (p_cov_status_clear);

	property p_cov_irq_rise;
		!irq ##1 irq;
	endproperty
	c_cov_irq_rise: cover property (p_cov_irq_rise);

endmodule : iim_regs

// [common/iim_pkg.sv]
/*
 Constants and types of the interrupt mask and holding register bank.
 Assumes one clock, an APB master with byte addresses, and a serial engine on the same clock.
*/
package iim_pkg;

	// ==========================================================
	// Bus widths and register offsets.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_STATUS_CLEAR = 8'h24;
	localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h28;
	localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h2C;
	localparam logic [7:0] OFS_IRQ_MASK_STATE = 8'h30;
	localparam logic [7:0] OFS_RX_BYTE_HOLDING = 8'h34;
	localparam logic [7:0] OFS_TX_BYTE_HOLDING = 8'h38;

	// ==========================================================
	// Flag positions, shared by status, enable, disable and mask.
	localparam int NFLAG = 12;
	localparam int BIT_TRANSFER_DONE = 0;
	localparam int BIT_RX_BYTE_READY = 1;
	localparam int BIT_TX_HOLDING_EMPTY = 2;
	localparam int BIT_ADDRESSED_AS_SLAVE = 4;
	localparam int BIT_GENERAL_CALL_SEEN = 5;
	localparam int BIT_RX_OVERRUN = 6;
	localparam int BIT_NACK = 8;
	localparam int BIT_ARBITRATION_LOST = 9;
	localparam int BIT_CLOCK_STRETCHED = 10;
	localparam int BIT_SLAVE_ACCESS_ENDED = 11;
	localparam logic [11:0] FLAG_VALID = 12'hF77;
	localparam logic [11:0] FLAG_LEVEL = 12'h411;
	localparam logic [11:0] FLAG_EVENT = 12'hB60;
	localparam logic [11:0] FLAG_RESET = 12'h000;
	localparam logic [11:0] MASK_RESET = 12'h000;
	localparam logic [7:0] BYTE_RESET = 8'h00;

	// ==========================================================
	// Types.
	typedef enum logic [2:0] {
		REG_NONE,
		REG_STATUS,
		REG_STATUS_CLEAR,
		REG_IRQ_ENABLE_SET,
		REG_IRQ_ENABLE_CLEAR,
		REG_IRQ_MASK_STATE,
		REG_RX_BYTE_HOLDING,
		REG_TX_BYTE_HOLDING
	} iim_reg_t;

	typedef enum logic {
		PH_IDLE,
		PH_ANSWER
	} iim_phase_t;

	typedef struct packed {
		logic [11:0] level;
		logic [11:0] event_set;
		logic rx_load;
		logic [7:0] rx_data;
		logic tx_take;
	} iim_eng_t;

endpackage : iim_pkg

// [design/iim_flag_bank.sv]
/*
 Bank of status flags: level flags follow the engine, the others are sticky.
 Assumes set and clear vectors come from logic on the same clock.
*/
`timescale 1ns/1ps
module iim_flag_bank #(
	parameter int WIDTH = iim_pkg::NFLAG,
	parameter logic [WIDTH-1:0] LEVEL = iim_pkg::FLAG_LEVEL,
	parameter logic [WIDTH-1:0] RESET = iim_pkg::FLAG_RESET
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] level_in,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	output logic [WIDTH-1:0] flags
);
	import iim_pkg::*;

	// ==========================================================
	// One flop per flag; a set in the clearing cycle wins.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			logic q;
			logic next_q;
			assign next_q = LEVEL[i] ? level_in[i] : (set_in[i] | (q & ~clr_in[i]));
			assign flags[i] = q;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					q <= RESET[i];
				end else begin
					q <= next_q;
				end
			end
		end
	endgenerate

endmodule : iim_flag_bank

// [design/iim_apb_slave.sv]
/*
 APB slave front end: address decode and a one-wait-free answer per transfer.
 Assumes a compliant APB master; pready rises in the access cycle.
*/
`timescale 1ns/1ps
module iim_apb_slave (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [iim_pkg::ADDR_W-1:0] paddr,
	output logic pready,
	output logic pslverr,
	output logic cap,
	output iim_pkg::iim_reg_t cap_reg,
	output iim_pkg::iim_reg_t take_reg,
	output logic wr_take,
	output logic rd_take
);
	import iim_pkg::*;

	// ==========================================================
	// Decode and strobes.
	iim_phase_t phase;
	logic hit;
	logic take;
	assign cap = psel && !penable && (phase == PH_IDLE);
	assign cap_reg = (paddr == OFS_STATUS) ? REG_STATUS :
		(paddr == OFS_STATUS_CLEAR) ? REG_STATUS_CLEAR :
		(paddr == OFS_IRQ_ENABLE_SET) ? REG_IRQ_ENABLE_SET :
		(paddr == OFS_IRQ_ENABLE_CLEAR) ? REG_IRQ_ENABLE_CLEAR :
		(paddr == OFS_IRQ_MASK_STATE) ? REG_IRQ_MASK_STATE :
		(paddr == OFS_RX_BYTE_HOLDING) ? REG_RX_BYTE_HOLDING :
		(paddr == OFS_TX_BYTE_HOLDING) ? REG_TX_BYTE_HOLDING : REG_NONE;
	assign hit = (cap_reg != REG_NONE);
	assign take = (phase == PH_ANSWER) && psel && penable;
	assign wr_take = take && pwrite;
	assign rd_take = take && !pwrite;

	// ==========================================================
	// Phase tracking; unmapped addresses answer with an error.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PH_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			take_reg <= REG_NONE;
		end else begin
			case (phase)
				PH_IDLE: begin
					if (cap) begin
						phase <= PH_ANSWER;
						pready <= 1'b1;
						pslverr <= !hit;
						take_reg <= cap_reg;
					end
				end
				PH_ANSWER: begin
					phase <= PH_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
				default: begin
					phase <= PH_IDLE;
					pready <= 1'b0;
					pslverr <= 1'b0;
				end
			endcase
		end
	end

endmodule : iim_apb_slave

// [verif/testbench.sv]
/*
 Self-checking testbench of the interrupt mask and holding register bank.
 Assumes the package and the register bank top; the bench plays APB master and serial engine.
*/
`timescale 1ns/1ps
module testbench;
	import iim_pkg::*;

	// ==========================================================
	// Signals and design.
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata;
	logic [DATA_W-1:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	iim_eng_t eng;
	logic [BYTE_W-1:0] tx_byte;
	logic tx_holding_empty;
	logic rx_byte_ready;
	logic [DATA_W-1:0] rd;
	logic err;
	int miscompares;
	int check_count;
	int cycles;
	int ev_bits[5] = '{5, 6, 8, 9, 11};

	iim_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.eng(eng), .tx_byte(tx_byte), .tx_holding_empty(tx_holding_empty), .rx_byte_ready(rx_byte_ready));

	// ==========================================================
	// Clock and hang guard.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// The whole run needs well under two thousand cycles.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares = miscompares + 1;
			finish_test();
		end
	end

	// ==========================================================
	// Shared tasks.
	task automatic finish_test();
		if (miscompares == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Holds the request until pready is sampled high, then releases it.
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic eng_pulse(input logic [11:0] ev, input logic ld, input logic tk, input logic [7:0] d);
		@(posedge pclk);
		eng.event_set <= ev;
		eng.rx_load <= ld;
		eng.tx_take <= tk;
		eng.rx_data <= d;
		@(posedge pclk);
		eng.event_set <= 12'h000;
		eng.rx_load <= 1'b0;
		eng.tx_take <= 1'b0;
		repeat (2) @(posedge pclk);
		#1;
	endtask : eng_pulse

	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : settle

	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask after reset", rd, 32'h0000_0000);
		apb(1'b0, OFS_RX_BYTE_HOLDING, 32'h0);
		check("rx holding after reset", rd, 32'h0000_0000);
		apb(1'b0, OFS_TX_BYTE_HOLDING, 32'h0);
		check("tx holding after reset", rd, 32'h0000_0000);
		check("irq after reset", {31'h0, irq}, 32'h0);
	endtask : t_reset

	task automatic t_mask();
		apb(1'b1, OFS_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
		check("mapped write no error", {31'h0, err}, 32'h0);
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask all set", rd, 32'h0000_0F77);
		apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'h0000_0F00);
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask upper cleared", rd, 32'h0000_0077);
		apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_0000);
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask zero set", rd, 32'h0000_0077);
		apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'hFFFF_F088);
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask reserved clear", rd, 32'h0000_0077);
		apb(1'b1, OFS_IRQ_MASK_STATE, 32'h0000_0000);
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask write ignored", rd, 32'h0000_0077);
		apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'h0000_0F77);
		apb(1'b0, OFS_IRQ_MASK_STATE, 32'h0);
		check("mask all cleared", rd, 32'h0000_0000);
		apb(1'b0, 8'h3C, 32'h0);
		check("unmapped error", {31'h0, err}, 32'h1);
	endtask : t_mask

	task automatic t_rx();
		apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_0002);
		eng_pulse(12'h000, 1'b1, 1'b0, 8'hA5);
		check("rx ready set", {31'h0, rx_byte_ready}, 32'h1);
		check("irq rx", {31'h0, irq}, 32'h1);
		apb(1'b0, OFS_RX_BYTE_HOLDING, 32'h0);
		check("rx holding", rd, 32'h0000_00A5);
		settle(2);
		check("rx ready cleared", {31'h0, rx_byte_ready}, 32'h0);
		check("irq rx gone", {31'h0, irq}, 32'h0);
		// A read set up in the cycle right after the load must already see the new byte.
		fork
			eng_pulse(12'h000, 1'b1, 1'b0, 8'h3C);
			begin
				@(posedge pclk);
				apb(1'b0, OFS_RX_BYTE_HOLDING, 32'h0);
			end
		join
		check("rx holding at once", rd, 32'h0000_003C);
		check("rx ready read at once", {31'h0, rx_byte_ready}, 32'h0);
		apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'h0000_0002);
	endtask : t_rx

	task automatic t_tx();
		eng_pulse(12'h000, 1'b0, 1'b1, 8'h00);
		check("tx empty after take", {31'h0, tx_holding_empty}, 32'h1);
		apb(1'b1, OFS_TX_BYTE_HOLDING, 32'h1234_565A);
		settle(1);
		check("tx empty dropped", {31'h0, tx_holding_empty}, 32'h0);
		check("tx byte out", {24'h0, tx_byte}, 32'h0000_005A);
		apb(1'b0, OFS_TX_BYTE_HOLDING, 32'h0);
		check("tx holding read", rd, 32'h0000_005A);
	endtask : t_tx

	task automatic t_events();
		apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_0B60);
		foreach (ev_bits[i]) begin
			eng_pulse(12'(1) << ev_bits[i], 1'b0, 1'b0, 8'h00);
			check("irq event", {31'h0, irq}, 32'h1);
			apb(1'b0, OFS_STATUS, 32'h0);
			check("status event", rd & 32'h0000_0B60, 32'(1) << ev_bits[i]);
			apb(1'b0, OFS_STATUS, 32'h0);
			check("status event cleared", rd & 32'h0000_0B60, 32'h0);
			settle(2);
			check("irq event gone", {31'h0, irq}, 32'h0);
		end
		apb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'h0000_0B60);
		eng_pulse(12'h200, 1'b0, 1'b0, 8'h00);
		check("irq masked event", {31'h0, irq}, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("masked event seen", rd & 32'h0000_0B60, 32'h0000_0200);
		eng_pulse(12'h040, 1'b0, 1'b0, 8'h00);
		apb(1'b1, OFS_STATUS_CLEAR, 32'h0000_0040);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status write clear", rd & 32'h0000_0B60, 32'h0);
	endtask : t_events

	task automatic t_levels();
		@(posedge pclk);
		eng.level <= 12'h411;
		apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_0400);
		settle(2);
		check("irq level", {31'h0, irq}, 32'h1);
		apb(1'b0, OFS_STATUS, 32'h0);
		check("status levels", rd & 32'h0000_0411, 32'h0000_0411);
		eng.level <= 12'h000;
		settle(3);
		check("irq level gone", {31'h0, irq}, 32'h0);
	endtask : t_levels

	// ==========================================================
	// Main sequence.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		eng = '0;
		miscompares = 0;
		check_count = 0;
		cycles = 0;
		t_reset();
		t_mask();
		t_rx();
		t_tx();
		t_events();
		t_levels();
		apb(1'b1, OFS_IRQ_ENABLE_SET, 32'h0000_0F77);
		t_reset();
		finish_test();
	end

endmodule : testbench
